// ==== rtl/wbps_regs.svh ====
// Purpose: offsets, field positions, reset values, codes and timing counts of the
//          write buffer program sequencer
// Assumes: 40 MHz core clock, 16-bit data words, 25-bit word addresses
// Notes:   included by the package only
`ifndef WBPS_REGS_SVH
`define WBPS_REGS_SVH
// apb register offsets
`define WBPS_OFS_CTRL    8'h00
`define WBPS_OFS_STATUS  8'h04
`define WBPS_OFS_COUNT   8'h08
`define WBPS_PROT_BASE   3'h1
// control fields and reset value
`define WBPS_CTRL_CLR    0
`define WBPS_CTRL_SPACE  1
`define WBPS_CTRL_ESUSP  3
`define WBPS_CTRL_RST    4'h0
`define WBPS_PROT_RST    32'h00000000
// status word bit positions
`define WBPS_ST_READY    7
`define WBPS_ST_FAIL     4
`define WBPS_ST_ABORT    3
`define WBPS_ST_PSUSP    2
`define WBPS_ST_ESUSP    1
// address layout
`define WBPS_AW          25
`define WBPS_SECT_LSB    17
`define WBPS_LINE_LSB    8
// command sequence codes
`define WBPS_UNLK1_ADDR  12'h555
`define WBPS_UNLK1_DATA  8'hAA
`define WBPS_UNLK2_ADDR  12'h2AA
`define WBPS_UNLK2_DATA  8'h55
`define WBPS_CMD_WRBUF   16'h0025
`define WBPS_CMD_CONFIRM 16'h0029
`define WBPS_CMD_SUSPEND 16'h00B0
`define WBPS_CMD_RESUME  16'h0030
`define WBPS_CMD_CLRST   16'h0071
`define WBPS_CNT_MAX     16'h00FF
`define WBPS_ERASED      16'hFFFF
// timing: embedded program time and core rate
`define WBPS_T_PROG_US   475
`define WBPS_CLK_MHZ     40
`define WBPS_PROG_CYC    (`WBPS_T_PROG_US * `WBPS_CLK_MHZ)
`endif

// ==== rtl/wbps_pkg.sv ====
// Purpose: types shared by the sequencer
// Assumes: constants come from wbps_regs.svh
// Notes:   command writes travel as one packed struct
`include "wbps_regs.svh"
package wbps_pkg;
   // one command write from the host
   typedef struct packed {
      logic                    we;    // write strobe
      logic [`WBPS_AW-1:0]     addr;  // word address
      logic [15:0]             data;  // write data
   } wbps_cmd_t;
   // sequencer states
   typedef enum logic [3:0] {
      S_IDLE  = 4'b0000,
      S_UNLK1 = 4'b0001,
      S_UNLK2 = 4'b0010,
      S_CNT   = 4'b0011,
      S_LOAD0 = 4'b0100,
      S_LOADN = 4'b0101,
      S_CONF  = 4'b0110,
      S_BUSY  = 4'b0111,
      S_SUSP  = 4'b1000
   } wbps_state_t;
   // address space selection
   typedef enum logic [1:0] {
      SPACE_MAIN   = 2'b00,
      SPACE_SECURE = 2'b01,
      SPACE_OTH2   = 2'b10,
      SPACE_OTH3   = 2'b11
   } wbps_space_t;
endpackage : wbps_pkg

// ==== rtl/wbps_top.sv ====
// Purpose: write-to-buffer program sequencer with apb status and control
// Assumes: link clock is slow against i_mclk; array read data follows o_arr_addr
//          within the same cycle
// Notes:   command write is taken at a rising edge of the synchronised link clock
// Function
// - program only one aligned 512-byte line
// - buffer words start as all ones
// - only main array or secure region
// - word count write, same sector
// - abort on word count above 255
// - protected sector fails without programming
// - first load selects line, sector checked
// - loading writes are data, counter decrements
// - load outside line aborts, abort flag
// - confirm 0029h starts busy embedded programming
// - missing or wrong confirm aborts
// - abort sets fail and abort flags
// - success or clear command clears fail
// - program suspendable, resume returns to busy state
// - reset ends the sequence at once
// - programming only turns ones into zeros
// - busy ignores all but suspend, status
//
// Register access over APB and the register addresses were left to the implementer.
module wbps_top #(
   parameter int unsigned PROG_CYCLES = `WBPS_PROG_CYC  // embedded program length
) (
   input  wire logic                i_mclk,      // core clock
   input  wire logic                i_resetn,    // sync reset, active low
   input  wire logic                i_lk_ck,     // link clock from host
   input  wire wbps_pkg::wbps_cmd_t i_lk_cmd,    // link command write
   input  wire logic                i_psel,      // apb select
   input  wire logic                i_penable,   // apb enable
   input  wire logic                i_pwrite,    // apb direction
   input  wire logic [7:0]          i_paddr,     // apb byte address
   input  wire logic [31:0]         i_pwdata,    // apb write data
   output logic      [31:0]         o_prdata,    // apb read data
   output logic                     o_pready,    // apb ready
   output logic                     o_pslverr,   // apb error
   output logic      [7:0]          o_status,    // status word
   output logic      [`WBPS_AW-1:0] o_arr_addr,  // array word address
   output logic                     o_arr_we,    // array write strobe
   output logic      [15:0]         o_arr_wdata, // array write data
   input  wire logic [15:0]         i_arr_rdata  // array read data
);
   import wbps_pkg::*;

   // link synchroniser stages
   logic        ck_s1, ck_s2, ck_s3;      // link clock stages
   wbps_cmd_t   cmd_s1, cmd_s2;           // command stages
   // sequencer state
   wbps_state_t state, next_state;        // current and next state
   logic [7:0]  sect;                     // captured sector
   logic [16:0] line;                     // captured line
   logic [7:0]  wcnt;                     // remaining word counter
   logic [255:0] mask;                    // loaded word marks
   logic [15:0] buf_mem [256];            // write buffer words
   logic        fail, abrt;               // sticky status flags
   logic [19:0] timer;                    // program time counter
   logic [7:0]  st_idx;                   // stream word index
   logic        st_ph, st_act;            // stream phase and activity
   logic [3:0]  ctrl;                     // control register
   logic [31:0] prot [8];                 // sector protection bits
   // sequencer events
   logic        abort_ev, load_ev, preset_ev, prot_fail, start_ev, clr_cmd;

   // two-stage synchroniser plus edge stage
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         ck_s1  <= 1'b0;
         ck_s2  <= 1'b0;
         ck_s3  <= 1'b0;
         cmd_s1 <= '0;
         cmd_s2 <= '0;
      end
      else
      begin
         ck_s1  <= i_lk_ck;
         ck_s2  <= ck_s1;
         ck_s3  <= ck_s2;
         cmd_s1 <= i_lk_cmd;
         cmd_s2 <= cmd_s1;
      end
   end

   // command decode
   wire         wr_ev     = ck_s2 & ~ck_s3 & cmd_s2.we;   // one write taken
   wire [7:0]   ev_sect   = cmd_s2.addr[`WBPS_AW-1:`WBPS_SECT_LSB];
   wire [16:0]  ev_line   = cmd_s2.addr[`WBPS_AW-1:`WBPS_LINE_LSB];
   wire [7:0]   ev_word   = cmd_s2.addr[`WBPS_LINE_LSB-1:0];
   wire [15:0]  ev_data   = cmd_s2.data;
   wire         is_unlk1  = (cmd_s2.addr[11:0] == `WBPS_UNLK1_ADDR)
                          & (ev_data[7:0] == `WBPS_UNLK1_DATA);
   wire         is_unlk2  = (cmd_s2.addr[11:0] == `WBPS_UNLK2_ADDR)
                          & (ev_data[7:0] == `WBPS_UNLK2_DATA);
   wire         sect_ok   = (ev_sect == sect);
   wire         line_ok   = (ev_line == line);
   wire         wc_big    = (ev_data > `WBPS_CNT_MAX);
   wire [8:0]   cnt_dec   = {1'b0, wcnt} - 9'h001;
   wire         borrow    = cnt_dec[8];
   wire [1:0]   ctrl_spc  = ctrl[`WBPS_CTRL_SPACE+1:`WBPS_CTRL_SPACE];
   wire         space_ok  = (ctrl_spc == SPACE_MAIN) | (ctrl_spc == SPACE_SECURE);
   wire         prot_hit  = prot[ev_sect[7:5]][ev_sect[4:0]];
   wire         done_ev   = (state == S_BUSY) & (timer == 20'h00000) & ~st_act;
   wire         busy      = (state == S_BUSY) | (state == S_SUSP);

   // next state and sequencer events
   always_comb
   begin
      next_state = state;
      abort_ev   = 1'b0;
      load_ev    = 1'b0;
      preset_ev  = 1'b0;
      prot_fail  = 1'b0;
      start_ev   = 1'b0;
      clr_cmd    = 1'b0;
      if (wr_ev)
      begin
         case (state)
            // standby: first unlock or clear status
            S_IDLE:
            begin
               if (is_unlk1)
                  next_state = S_UNLK1;
               else if (ev_data == `WBPS_CMD_CLRST)
                  clr_cmd = 1'b1;
            end
            S_UNLK1:
               next_state = is_unlk2 ? S_UNLK2 : S_IDLE;
            S_UNLK2:
            begin
               if (ev_data != `WBPS_CMD_WRBUF || !space_ok)
                  next_state = S_IDLE;
               else if (prot_hit)
               begin
                  prot_fail  = 1'b1;
                  next_state = S_IDLE;
               end
               else
               begin
                  preset_ev  = 1'b1;
                  next_state = S_CNT;
               end
            end
            S_CNT:
            begin
               if (!sect_ok || wc_big)
                  abort_ev = 1'b1;
               else
                  next_state = S_LOAD0;
            end
            S_LOAD0:
            begin
               if (!sect_ok)
                  abort_ev = 1'b1;
               else
               begin
                  load_ev    = 1'b1;
                  next_state = borrow ? S_CONF : S_LOADN;
               end
            end
            S_LOADN:
            begin
               if (!line_ok)
                  abort_ev = 1'b1;
               else
               begin
                  load_ev    = 1'b1;
                  next_state = borrow ? S_CONF : S_LOADN;
               end
            end
            S_CONF:
            begin
               if (sect_ok && ev_data == `WBPS_CMD_CONFIRM)
               begin
                  start_ev   = 1'b1;
                  next_state = S_BUSY;
               end
               else
                  abort_ev = 1'b1;
            end
            S_BUSY:
            begin
               if (ev_data == `WBPS_CMD_SUSPEND)
                  next_state = S_SUSP;
            end
            // suspended: wait for resume
            S_SUSP:
            begin
               if (ev_data == `WBPS_CMD_RESUME)
                  next_state = S_BUSY;
            end
            default:
               next_state = S_IDLE;
         endcase
      end
      // completion returns to standby
      if (abort_ev || done_ev)
         next_state = S_IDLE;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
         state <= S_IDLE;
      else
         state <= next_state;
   end

   wire apb_clr;                          // software clear from control write
   wire clr_any = clr_cmd | apb_clr;
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         fail <= 1'b0;
         abrt <= 1'b0;
      end
      else
      begin
         fail <= (fail & ~clr_any & ~done_ev) | abort_ev | prot_fail;
         abrt <= (abrt & ~clr_any & ~done_ev) | abort_ev;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         sect <= 8'h00;
         line <= 17'h00000;
         wcnt <= 8'h00;
         mask <= '0;
      end
      else if (preset_ev)
      begin
         sect <= ev_sect;
         mask <= '0;
      end
      else if (wr_ev && state == S_CNT && !abort_ev)
         wcnt <= ev_data[7:0];
      else if (load_ev)
      begin
         wcnt           <= cnt_dec[7:0];
         mask[ev_word]  <= 1'b1;
         if (state == S_LOAD0)
            line <= ev_line;
      end
   end

   // buffer word storage
   always_ff @(posedge i_mclk)
   begin
      if (load_ev)
         buf_mem[ev_word] <= ev_data;
   end

   // unloaded words read as erased
   wire [15:0] line_word = mask[st_idx] ? buf_mem[st_idx] : `WBPS_ERASED;

   // embedded program timer and line stream
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         timer       <= 20'h00000;
         st_idx      <= 8'h00;
         st_ph       <= 1'b0;
         st_act      <= 1'b0;
         o_arr_addr  <= '0;
         o_arr_we    <= 1'b0;
         o_arr_wdata <= 16'h0000;
      end
      else if (start_ev)
      begin
         timer  <= 20'(PROG_CYCLES);
         st_idx <= 8'h00;
         st_ph  <= 1'b0;
         st_act <= 1'b1;
      end
      else if (state == S_BUSY)
      begin
         if (timer != 20'h00000)
            timer <= timer - 20'h00001;
         o_arr_we <= st_act & st_ph;
         if (st_act && !st_ph)
         begin
            o_arr_addr <= {line, st_idx};
            st_ph      <= 1'b1;
         end
         else if (st_act)
         begin
            o_arr_wdata <= i_arr_rdata & line_word;
            st_ph       <= 1'b0;
            st_idx      <= st_idx + 8'h01;
            st_act      <= (st_idx != 8'hFF);
         end
      end
      else
         o_arr_we <= 1'b0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
         o_status <= 8'h80;
      else
         o_status <= {~busy, 2'b00, fail, abrt, state == S_SUSP, ctrl[`WBPS_CTRL_ESUSP], 1'b0};
   end

   // apb decode
   wire       apb_setup = i_psel & ~i_penable;
   wire       apb_wr    = i_psel & i_penable & o_pready & i_pwrite;
   wire       sel_ctrl  = (i_paddr == `WBPS_OFS_CTRL);
   wire       sel_stat  = (i_paddr == `WBPS_OFS_STATUS);
   wire       sel_cnt   = (i_paddr == `WBPS_OFS_COUNT);
   wire       sel_prot  = (i_paddr[7:5] == `WBPS_PROT_BASE) & (i_paddr[1:0] == 2'b00);
   wire [2:0] prot_idx  = i_paddr[4:2];
   wire       mapped    = sel_ctrl | sel_stat | sel_cnt | sel_prot;
   wire [31:0] rd_mux   = sel_ctrl ? {28'h0000000, ctrl[3:1], 1'b0} :
                          sel_stat ? {24'h000000, o_status} :
                          sel_cnt  ? {20'h00000, state, wcnt} :
                          sel_prot ? prot[prot_idx] : 32'h00000000;
   assign apb_clr = apb_wr & sel_ctrl & i_pwdata[`WBPS_CTRL_CLR];

   // apb answer: one wait-free access phase
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h00000000;
      end
      else
      begin
         o_pready  <= apb_setup;
         o_pslverr <= apb_setup & ~mapped;
         if (apb_setup)
            o_prdata <= rd_mux;
      end
   end

   // control register, clear bit self-clears
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
         ctrl <= `WBPS_CTRL_RST;
      else if (apb_wr && sel_ctrl)
         ctrl <= {i_pwdata[3:1], 1'b0};
   end

   // protection registers, one per group of 32 sectors
   for (genvar g = 0; g < 8; g++)
   begin : g_prot
      always_ff @(posedge i_mclk)
      begin
         if (!i_resetn)
            prot[g] <= `WBPS_PROT_RST;
         else if (apb_wr && sel_prot && prot_idx == 3'(g))
            prot[g] <= i_pwdata;
      end
   end

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_resetn);

   AST_ABORT_FLAGS: assert property (abort_ev |=> fail && abrt && state == S_IDLE)
      else $error("abort did not set both flags");
   AST_WC_LIMIT: assert property (wr_ev && state == S_CNT && sect_ok && wc_big
      |=> state == S_IDLE && abrt)
      else $error("oversize word count not aborted");
   AST_LINE_ABORT: assert property (wr_ev && state == S_LOADN && !line_ok
      |=> abrt && state == S_IDLE)
      else $error("load outside line not aborted");
   AST_PRESET: assert property (preset_ev |=> mask == '0 && state == S_CNT)
      else $error("buffer not preset");
   AST_PROT: assert property (prot_fail |=> fail && state == S_IDLE && !st_act)
      else $error("protected sector not failed");
   AST_SPACE: assert property (wr_ev && state == S_UNLK2 && !space_ok |=> state == S_IDLE)
      else $error("other address space accepted");
   AST_BUSY_IGNORE: assert property (state == S_BUSY && wr_ev
      && ev_data != `WBPS_CMD_SUSPEND |=> state inside {S_BUSY, S_IDLE})
      else $error("command accepted while busy");
   AST_CONFIRM: assert property (start_ev |=> state == S_BUSY ##1 !o_status[`WBPS_ST_READY])
      else $error("confirm did not start program");
   AST_SUCCESS: assert property (done_ev |=> !fail && !abrt && state == S_IDLE)
      else $error("success did not clear fail");
   AST_COUNT: assert property (load_ev && wcnt == 8'h00 |=> state == S_CONF)
      else $error("underflow did not expect confirm");
   AST_ONES: assert property (o_arr_we && !$past(o_arr_we)
      |-> (o_arr_wdata & ~$past(i_arr_rdata)) == 16'h0000)
      else $error("program set a zero bit to one");
   AST_RESET: assert property (@(posedge i_mclk) disable iff (1'b0) !i_resetn
      |=> state == S_IDLE)
      else $error("reset did not end the sequence");

   COV_PROGRAM: cover property (start_ev ##[1:1000] o_arr_we);
   COV_ABORT: cover property (state == S_LOADN ##1 abort_ev);
   COV_SUSPEND: cover property (state == S_SUSP ##[1:1000] state == S_BUSY);
endmodule : wbps_top

// ==== test/wbps_host.sv ====
// Purpose: host side of the link, one command write per link clock pulse
// Assumes: core clock drives it, at least 14 core cycles to a link period
// Notes:   link clock low between writes, released lines inverted
module wbps_host (
   input  wire logic           i_clk,    // core clock
   input  wire logic           i_go,     // start one write
   input  wire logic [24:0]    i_addr,   // word address
   input  wire logic [15:0]    i_data,   // write data
   output logic                o_lk_ck,  // link clock
   output wbps_pkg::wbps_cmd_t o_lk_cmd, // link command
   output logic                o_done    // write finished
);
   timeunit 1ns;
   timeprecision 1ns;
   import wbps_pkg::*;
   logic [3:0] cnt; // frame position
   // single driver process: quiet lines at start, then one frame per request
   // command 4 cycles before the rise, held 7 after it
   initial
   begin
      cnt      = 4'h0;
      o_lk_ck  = 1'b0;
      o_lk_cmd = '0;
      o_done   = 1'b0;
      forever
      begin
         @(posedge i_clk);
         o_done <= 1'b0;
         if (cnt != 4'h0)
            cnt <= cnt + 4'h1;
         // start only when idle and not in the done cycle
         if (i_go && cnt == 4'h0 && !o_done)
         begin
            cnt      <= 4'h1;
            o_lk_cmd <= {1'b1, i_addr, i_data};
         end
         if (cnt == 4'h4)
            o_lk_ck <= 1'b1;
         if (cnt == 4'h8)
            o_lk_ck <= 1'b0;
         // released lines show the inverse
         if (cnt == 4'hB)
            o_lk_cmd <= ~o_lk_cmd;
         if (cnt == 4'hC)
         begin
            cnt    <= 4'h0;
            o_done <= 1'b1;
         end
      end
   end
endmodule : wbps_host

// ==== test/tb_top.sv ====
// Purpose: self-checking bench of the buffer program sequencer
// Assumes: host model on the link, program time cut to 600 cycles
// Notes:   array reads return 7FFF with the low address byte flipped
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import wbps_pkg::*;
   localparam logic [24:0] LB = 25'h0040300; // sector 2, line 3
   logic        clk, resetn, psel, penable, pwrite, pready, pslverr, rd_err;
   logic [7:0]  paddr, status;
   logic [31:0] pwdata, prdata, rd_data;
   logic [24:0] arr_addr, la;
   logic [15:0] arr_wdata, arr_rdata, ldat;
   logic        arr_we, lk_ck, go, done;
   wbps_cmd_t   lk_cmd;
   logic [15:0] wr [int]; // array writes seen
   int          nwr, n0, n_mismatch, comparisons;
   wbps_host i_wbps_host (.i_clk(clk), .i_go(go), .i_addr(la), .i_data(ldat),
      .o_lk_ck(lk_ck), .o_lk_cmd(lk_cmd), .o_done(done));
   wbps_top #(.PROG_CYCLES(600)) i_wbps_top (.i_mclk(clk), .i_resetn(resetn),
      .i_lk_ck(lk_ck), .i_lk_cmd(lk_cmd), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .o_status(status),
      .o_arr_addr(arr_addr), .o_arr_we(arr_we), .o_arr_wdata(arr_wdata),
      .i_arr_rdata(arr_rdata));
   assign arr_rdata = 16'h7FFF ^ {8'h00, arr_addr[7:0]};
   // core clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // collect array writes
   always @(posedge clk)
      if (arr_we === 1'b1)
      begin
         wr[int'(arr_addr)] = arr_wdata;
         nwr++;
      end
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task st(input logic [7:0] e);
      chk("status", {24'h0, status}, {24'h0, e});
   endtask : st
   // one apb transfer, waits for ready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      t = 0;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (pready !== 1'b1 && t < 20);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (t >= 20)
         chk("apb wait", 0, 1);
   endtask : apb
   // one link write through the host model
   task lk(input logic [24:0] a, input logic [15:0] d);
      int t;
      @(posedge clk);
      go <= 1'b1;
      la <= a;
      ldat <= d;
      t = 0;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (done !== 1'b1 && t < 40);
      go <= 1'b0;
      if (t >= 40)
         chk("link wait", 0, 1);
   endtask : lk
   task prog(input logic [7:0] sec, input logic [24:0] ld, input int n,
             input logic [15:0] cnt_w, input logic [15:0] cf);
      lk(25'h555, 16'h00AA);
      lk(25'h2AA, 16'h0055);
      lk({sec, 17'h00ABC}, 16'h0025);
      lk({sec, 17'h00000}, cnt_w);
      // sequential loads from ld upward, one word each
      for (int k = 0; k < n; k++)
         lk(ld + 25'(k), 16'hAAAA ^ {k[7:0], 8'h00});
      lk({sec, 17'h1FFFF}, cf);
   endtask : prog
   task wait_rdy;
      int t;
      t = 0;
      while (status[7] !== 1'b1 && t < 2000)
      begin
         @(posedge clk);
         t++;
      end
      repeat (2) @(posedge clk);
      if (t >= 2000)
         chk("ready wait", 0, 1);
   endtask : wait_rdy
   task ab_clr(input int k);
      st(8'h98);
      if (k % 2 == 0)
         apb(1'b1, 8'h00, 32'h1);
      else
         lk(25'h555, 16'h0071);
      repeat (3) @(posedge clk);
      st(8'h80);
   endtask : ab_clr
   task end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   // hang guard
   initial
   begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      end_of_test;
   end
   // test sequence
   initial
   begin
      {resetn, psel, penable, pwrite, go} = '0;
      {paddr, pwdata, la, ldat} = '0;
      {nwr, n_mismatch, comparisons} = '0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      st(8'h80);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl", rd_data, 32'h0);
      apb(1'b1, 8'h04, 32'hFF);
      apb(1'b0, 8'h04, 32'h0);
      chk("status reg", rd_data, 32'h80);
      apb(1'b0, 8'h3C, 32'h0);
      chk("prot7", rd_data, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {31'h0, rd_err}, 32'h1);
      $display("test registers done");
      prog(8'h02, LB + 25'h10, 2, 16'h0001, 16'h0029);
      st(8'h00);
      lk(25'h0, 16'h0071);
      st(8'h00);
      lk(25'h0, 16'h00B0);
      st(8'h04);
      lk(25'h0, 16'h0029);
      st(8'h04);
      lk(25'h0, 16'h0030);
      st(8'h00);
      wait_rdy;
      st(8'h80);
      chk("writes", nwr, 256);
      chk("word 10", {16'h0, wr[int'(LB) + 16]}, 32'h2AAA);
      chk("word 11", {16'h0, wr[int'(LB) + 17]}, 32'h2BAA);
      chk("word 00", {16'h0, wr[int'(LB)]}, 32'h7FFF);
      chk("word FF", {16'h0, wr[int'(LB) + 255]}, 32'h7F00);
      $display("test program done");
      prog(8'h02, LB, 0, 16'h0100, 16'h0029);
      ab_clr(0);
      prog(8'h02, LB + 25'hFF, 2, 16'h0001, 16'h0029);
      ab_clr(1);
      prog(8'h02, 25'h0060300, 1, 16'h0000, 16'h0029);
      ab_clr(2);
      prog(8'h02, LB, 2, 16'h0001, 16'h0030);
      ab_clr(3);
      prog(8'h02, LB, 1, 16'h0001, 16'h0029);
      ab_clr(4);
      lk(25'h555, 16'h00AA);
      lk(25'h2AA, 16'h0055);
      lk({8'h02, 17'h00000}, 16'h0025);
      lk({8'h03, 17'h00000}, 16'h0000);
      ab_clr(5);
      prog(8'h02, LB, 2, 16'h0001, 16'h0030);
      st(8'h98);
      prog(8'h02, LB, 1, 16'h0000, 16'h0029);
      wait_rdy;
      st(8'h80);
      $display("test aborts done");
      apb(1'b1, 8'h20, 32'h4);
      apb(1'b0, 8'h20, 32'h0);
      chk("prot0", rd_data, 32'h4);
      n0 = nwr;
      prog(8'h02, LB, 1, 16'h0000, 16'h0029);
      st(8'h90);
      chk("protected writes", nwr, n0);
      apb(1'b1, 8'h20, 32'h0);
      apb(1'b1, 8'h00, 32'h5);
      prog(8'h02, LB, 1, 16'h0000, 16'h0029);
      st(8'h80);
      chk("other space writes", nwr, n0);
      apb(1'b1, 8'h00, 32'hA);
      repeat (3) @(posedge clk);
      st(8'h82);
      prog(8'h02, LB, 1, 16'h0000, 16'h0029);
      st(8'h02);
      wait_rdy;
      st(8'h82);
      chk("word 10 preset", {16'h0, wr[int'(LB) + 16]}, 32'h7FEF);
      chk("word 00 secure", {16'h0, wr[int'(LB)]}, 32'h2AAA);
      apb(1'b1, 8'h00, 32'h0);
      $display("test space done");
      prog(8'h02, LB, 1, 16'h0000, 16'h0029);
      repeat (20) @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      n0 = nwr;
      st(8'h80);
      apb(1'b0, 8'h08, 32'h0);
      chk("count state", {28'h0, rd_data[11:8]}, 32'h0);
      repeat (700) @(posedge clk);
      chk("writes stop", nwr, n0);
      $display("test reset done");
      end_of_test;
   end
endmodule : tb_top
